//--- verilog/pmcr_misc_config.sv
// Miscellaneous bus configuration register and the logic it steers.
`timescale 1ns/1ps
`default_nettype none
module pmcr_misc_config (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_bus_reset,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    input wire logic i_eeprom_present,
    input wire logic i_eeprom_valid,
    input wire logic [3:0] i_eeprom_word,
    input wire logic [15:0] i_eeprom_data,
    output logic o_pme_from_d3cold_support,
    output logic o_vendor_id_bit26,
    input wire logic i_pme_enable,
    input wire logic i_unmasked_irq,
    input wire logic i_interrupt_mask_master_enable,
    output logic o_pme_request,
    input wire logic i_master_read_req,
    input wire logic [7:0] i_master_read_phases,
    output logic [3:0] o_master_read_cmd,
    output logic o_master_read_cmd_valid,
    input wire logic i_link_access,
    input wire logic i_link_clock_active,
    output logic o_link_done,
    output logic [31:0] o_link_rdata,
    output logic o_link_target_abort,
    input wire logic [1:0] i_gpio_drive,
    input wire logic [1:0] i_gpio_enable,
    output logic [1:0] o_gpio_out,
    output logic [1:0] o_gpio_oe,
    output logic o_serial_clock,
    output logic o_serial_data,
    input wire logic i_link_clock_request,
    input wire logic i_bus_clock_request,
    output logic o_link_clock_gate_enable,
    output logic o_bus_clock_gate_enable,
    input wire logic i_multifunction_pin_6,
    output logic o_multifunction_pin_6,
    output logic o_multifunction_pin_6_oe
);
    import pmcr_pkg::*;

    default clocking cfg_cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    typedef struct packed {
        logic [15:0] cfg;
        logic [31:0] rdata;
        logic rvalid;
        logic pme;
        logic link_done;
        logic [31:0] link_rdata;
        logic link_abort;
        logic [1:0] gpio_out;
        logic [1:0] gpio_oe;
        logic serial_clock;
        logic serial_data;
        logic link_gate;
        logic bus_gate;
        logic clkrun_out;
        logic clkrun_oe;
    } pmcr_state_t;

    pmcr_state_t st;
    pmcr_state_t next_st;
    logic clkrun_level;
    logic cfg_hit;
    logic [31:0] read_word;

    pmcr_pin_sync u_clkrun_sync (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_pin(i_multifunction_pin_6),
        .o_level(clkrun_level)
    );

    pmcr_read_cmd u_read_cmd (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_req(i_master_read_req),
        .i_select(st.cfg[PMCR_BIT_READ_SEL_HI:PMCR_BIT_READ_SEL_LO]),
        .i_phases(i_master_read_phases),
        .o_cmd(o_master_read_cmd),
        .o_cmd_valid(o_master_read_cmd_valid)
    );

    assign cfg_hit = (i_cfg_addr == PMCR_OFFSET);
    // The stored copy holds only writable bits, so reserved bits stay zero.
    assign read_word = {PMCR_UPPER_ZERO, st.cfg & PMCR_WRITE_MASK};

    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.link_done = 1'b0;
        next_st.link_abort = 1'b0;
        if (i_cfg_wr && cfg_hit) begin
            if (i_cfg_be[0]) begin
                next_st.cfg[7:0] =
                    i_cfg_wdata[7:0] & PMCR_WRITE_MASK[7:0];
            end
            if (i_cfg_be[1]) begin
                next_st.cfg[15:8] =
                    i_cfg_wdata[15:8] & PMCR_WRITE_MASK[15:8];
            end
        end
        // An EEPROM word arriving with a bus write wins over that write.
        if (i_eeprom_present && i_eeprom_valid &&
            i_eeprom_word == PMCR_EEPROM_WORD) begin
            next_st.cfg[PMCR_BIT_READ_SEL_HI:PMCR_BIT_READ_SEL_LO] =
                i_eeprom_data[1:0];
        end
        if (i_cfg_rd) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = cfg_hit ? read_word : PMCR_UNMAPPED_DATA;
        end
        next_st.pme = i_pme_enable && i_unmasked_irq &&
            (st.cfg[PMCR_BIT_PME_IGNORE] ||
             i_interrupt_mask_master_enable);
        if (i_link_access && !i_link_clock_active) begin
            if (st.cfg[PMCR_BIT_SUPPRESS_ABORT]) begin
                next_st.link_done = 1'b1;
                next_st.link_rdata = PMCR_ABSENT_LINK_DATA;
            end else begin
                next_st.link_abort = 1'b1;
            end
        end
        next_st.gpio_out = i_gpio_drive;
        if (st.cfg[PMCR_BIT_GPIO_ROUTE]) begin
            next_st.serial_clock = i_gpio_drive[1];
            next_st.serial_data = i_gpio_drive[0];
            next_st.gpio_oe = 2'b00;
        end else begin
            next_st.serial_clock = PMCR_SERIAL_IDLE;
            next_st.serial_data = PMCR_SERIAL_IDLE;
            next_st.gpio_oe = i_gpio_enable;
        end
        next_st.link_gate = st.cfg[PMCR_BIT_LINK_GATE_BYPASS] ||
            i_link_clock_request;
        next_st.bus_gate = st.cfg[PMCR_BIT_BUS_GATE_BYPASS] ||
            i_bus_clock_request;
        // The pin is low-active and open-drain; only a low is ever driven.
        next_st.clkrun_out = 1'b0;
        next_st.clkrun_oe = clkrun_level &&
            (st.cfg[PMCR_BIT_HOLD_BUS_CLOCK] || i_bus_clock_request);
        // A bus reset drops pending answers but keeps the stored fields.
        if (i_bus_reset) begin
            next_st.rvalid = 1'b0;
            next_st.link_done = 1'b0;
            next_st.link_abort = 1'b0;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
            st.cfg <= PMCR_RESET[15:0];
            st.serial_clock <= PMCR_SERIAL_IDLE;
            st.serial_data <= PMCR_SERIAL_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign o_cfg_rdata = st.rdata;
    assign o_cfg_rvalid = st.rvalid;
    assign o_pme_from_d3cold_support = st.cfg[PMCR_BIT_PME_FROM_D3COLD_SUPPORT];
    assign o_vendor_id_bit26 = st.cfg[PMCR_BIT_PME_IGNORE];
    assign o_pme_request = st.pme;
    assign o_link_done = st.link_done;
    assign o_link_rdata = st.link_rdata;
    assign o_link_target_abort = st.link_abort;
    assign o_gpio_out = st.gpio_out;
    assign o_gpio_oe = st.gpio_oe;
    assign o_serial_clock = st.serial_clock;
    assign o_serial_data = st.serial_data;
    assign o_link_clock_gate_enable = st.link_gate;
    assign o_bus_clock_gate_enable = st.bus_gate;
    assign o_multifunction_pin_6 = st.clkrun_out;
    assign o_multifunction_pin_6_oe = st.clkrun_oe;

    upper_zero_a: assert property (
        o_cfg_rvalid |-> o_cfg_rdata[31:16] == 16'h0000)
        else $error("Upper half of the read word is not zero.");

    d3cold_mirror_a: assert property (
        i_cfg_wr && cfg_hit && i_cfg_be[1] |=>
        o_pme_from_d3cold_support == $past(i_cfg_wdata[15]))
        else $error("Cold-state wake support did not follow the write.");

    rev_zero_a: assert property (
        o_cfg_rvalid |-> o_cfg_rdata[11] == 1'b0)
        else $error("Revision conform bit reads as one.");

    pme_gate_a: assert property (
        i_pme_enable && i_unmasked_irq && !i_interrupt_mask_master_enable |=>
        o_pme_request == $past(st.cfg[PMCR_BIT_PME_IGNORE]))
        else $error("Wake request ignores the master enable setting.");

    pme_free_a: assert property (
        st.cfg[PMCR_BIT_PME_IGNORE] |=>
        o_pme_request == $past(i_pme_enable && i_unmasked_irq))
        else $error("Wake request still depends on the master enable.");

    vendor_bit_a: assert property (
        i_cfg_wr && cfg_hit && i_cfg_be[1] |=>
        o_vendor_id_bit26 == $past(i_cfg_wdata[10]))
        else $error("Vendor bit 26 does not follow the ignore bit.");

    eeprom_load_a: assert property (
        i_eeprom_present && i_eeprom_valid &&
        i_eeprom_word == PMCR_EEPROM_WORD |=>
        st.cfg[9:8] == $past(i_eeprom_data[1:0]))
        else $error("Read command select was not loaded from the EEPROM.");

    reserved_mid_a: assert property (
        o_cfg_rvalid |-> o_cfg_rdata[14:12] == 3'b000 &&
        o_cfg_rdata[7:5] == 3'b000)
        else $error("Reserved middle bits read as nonzero.");

    link_answer_a: assert property (
        i_link_access && !i_link_clock_active && !i_bus_reset |=>
        (o_link_target_abort != o_link_done) &&
        (o_link_done == $past(st.cfg[PMCR_BIT_SUPPRESS_ABORT])))
        else $error("Stopped link access answered wrongly.");

    link_live_a: assert property (
        i_link_access && i_link_clock_active |=>
        !o_link_done && !o_link_target_abort)
        else $error("Access to a running link was answered here.");

    link_ones_a: assert property (
        o_link_done |-> o_link_rdata == PMCR_ABSENT_LINK_DATA)
        else $error("Suppressed abort did not return all ones.");

    gpio_route_a: assert property (
        st.cfg[PMCR_BIT_GPIO_ROUTE] && $stable(st.cfg) |=>
        o_gpio_oe == 2'b00 && o_serial_clock == $past(i_gpio_drive[1]) &&
        o_serial_data == $past(i_gpio_drive[0]))
        else $error("Routed general signals did not reach the serial lines.");

    serial_idle_a: assert property (
        !st.cfg[PMCR_BIT_GPIO_ROUTE] |=> o_serial_clock &&
        o_serial_data && o_gpio_oe == $past(i_gpio_enable))
        else $error("Unrouted general signals disturbed the serial lines.");

    gate_bypass_a: assert property (
        st.cfg[PMCR_BIT_LINK_GATE_BYPASS] |=> o_link_clock_gate_enable)
        else $error("Link clock gated despite bypass.");

    bus_bypass_a: assert property (
        st.cfg[PMCR_BIT_BUS_GATE_BYPASS] |=> o_bus_clock_gate_enable)
        else $error("Bus clock gated despite bypass.");

    clkrun_hold_a: assert property (
        st.cfg[PMCR_BIT_HOLD_BUS_CLOCK] && clkrun_level |=>
        o_multifunction_pin_6_oe && !o_multifunction_pin_6)
        else $error("Clock-run pin not held while the bus clock must run.");

    clkrun_free_a: assert property (
        !st.cfg[PMCR_BIT_HOLD_BUS_CLOCK] && !i_bus_clock_request |=>
        !o_multifunction_pin_6_oe)
        else $error("Clock-run pin held although the clock may stop.");

    bus_reset_keep_a: assert property (
        i_bus_reset && !i_cfg_wr && !i_eeprom_valid |=> $stable(st.cfg))
        else $error("Bus reset changed the configuration fields.");

    answer_kill_a: assert property (
        i_bus_reset |=> !o_cfg_rvalid && !o_link_done &&
        !o_link_target_abort)
        else $error("Bus reset let a pending answer through.");

    rvalid_pulse_a: assert property (
        i_cfg_rd && !i_bus_reset |=> o_cfg_rvalid)
        else $error("Read was not answered one cycle later.");

    miss_read_a: assert property (
        i_cfg_rd && !cfg_hit && !i_bus_reset |=>
        o_cfg_rdata == PMCR_UNMAPPED_DATA)
        else $error("Read at another offset returned nonzero data.");

    miss_write_a: assert property (
        i_cfg_wr && !cfg_hit && !i_eeprom_valid |=> $stable(st.cfg))
        else $error("Write at another offset changed the register.");
endmodule
`default_nettype wire

//--- verilog/pmcr_pkg.sv
// Package with offsets, field positions, reset values and command codes.
package pmcr_pkg;
    localparam logic [7:0] PMCR_OFFSET = 8'hf0;
    localparam logic [31:0] PMCR_RESET = 32'h0000_0000;
    localparam logic [15:0] PMCR_WRITE_MASK = 16'h871f;
    localparam logic [15:0] PMCR_UPPER_ZERO = 16'h0000;
    localparam logic [31:0] PMCR_UNMAPPED_DATA = 32'h0000_0000;
    localparam logic [31:0] PMCR_ABSENT_LINK_DATA = 32'hffff_ffff;
    localparam int PMCR_BIT_PME_FROM_D3COLD_SUPPORT = 15;
    localparam int PMCR_BIT_REV_CONFORM = 11;
    localparam int PMCR_BIT_PME_IGNORE = 10;
    localparam int PMCR_BIT_READ_SEL_HI = 9;
    localparam int PMCR_BIT_READ_SEL_LO = 8;
    localparam int PMCR_BIT_SUPPRESS_ABORT = 4;
    localparam int PMCR_BIT_GPIO_ROUTE = 3;
    localparam int PMCR_BIT_LINK_GATE_BYPASS = 2;
    localparam int PMCR_BIT_BUS_GATE_BYPASS = 1;
    localparam int PMCR_BIT_HOLD_BUS_CLOCK = 0;
    localparam logic [3:0] PMCR_EEPROM_WORD = 4'hc;
    localparam logic [7:0] PMCR_SHORT_PHASES = 8'h02;
    localparam logic [3:0] PMCR_CMD_MEM_READ = 4'h6;
    localparam logic [3:0] PMCR_CMD_MEM_READ_LINE = 4'he;
    localparam logic [3:0] PMCR_CMD_MEM_READ_MULTIPLE = 4'hc;
    localparam logic PMCR_PIN_IDLE = 1'b1;
    localparam logic PMCR_SERIAL_IDLE = 1'b1;

    function automatic logic [3:0] pmcr_read_cmd_for(
        input logic [1:0] sel,
        input logic [7:0] phases
    );
        logic [3:0] cmd;
        cmd = PMCR_CMD_MEM_READ_LINE;
        if (phases <= PMCR_SHORT_PHASES) begin
            cmd = PMCR_CMD_MEM_READ;
        end else begin
            case (sel)
                2'b01: cmd = PMCR_CMD_MEM_READ;
                2'b10: cmd = PMCR_CMD_MEM_READ_MULTIPLE;
                default: cmd = PMCR_CMD_MEM_READ_LINE;
            endcase
        end
        return cmd;
    endfunction
endpackage

//--- verilog/pmcr_pin_sync.sv
// Three-stage pin synchroniser that accepts a level once two stages agree.
`timescale 1ns/1ps
`default_nettype none
module pmcr_pin_sync (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_pin,
    output logic o_level
);
    import pmcr_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } pmcr_sync_t;

    pmcr_sync_t st;
    pmcr_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = i_pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '{default: PMCR_PIN_IDLE};
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
endmodule
`default_nettype wire

//--- verilog/pmcr_read_cmd.sv
// Selector of the bus master's read command for each master read request.
`timescale 1ns/1ps
`default_nettype none
module pmcr_read_cmd (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_req,
    input wire logic [1:0] i_select,
    input wire logic [7:0] i_phases,
    output logic [3:0] o_cmd,
    output logic o_cmd_valid
);
    import pmcr_pkg::*;

    default clocking cmd_cb @(posedge i_clock);
    endclocking
    default disable iff (!i_nrst);

    typedef struct packed {
        logic [3:0] cmd;
        logic valid;
    } pmcr_cmd_t;

    pmcr_cmd_t st;
    pmcr_cmd_t next_st;

    always_comb begin
        next_st = st;
        next_st.valid = i_req;
        if (i_req) begin
            next_st.cmd = pmcr_read_cmd_for(i_select, i_phases);
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '{PMCR_CMD_MEM_READ, 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign o_cmd = st.cmd;
    assign o_cmd_valid = st.valid;

    long_cmd_a: assert property (
        i_req && i_phases > PMCR_SHORT_PHASES |=> o_cmd_valid &&
        o_cmd == ($past(i_select) == 2'b10 ? PMCR_CMD_MEM_READ_MULTIPLE :
        ($past(i_select) == 2'b01 ? PMCR_CMD_MEM_READ :
        PMCR_CMD_MEM_READ_LINE)))
        else $error("Long read command does not match the selection.");

    short_cmd_a: assert property (
        i_req && i_phases <= PMCR_SHORT_PHASES |=>
        o_cmd_valid && o_cmd == PMCR_CMD_MEM_READ)
        else $error("Short read did not use the plain memory read.");
endmodule
`default_nettype wire

//--- test/pmcr_host_model.sv
// Host model that issues configuration cycles on the register bus.
`timescale 1ns/1ps
`default_nettype none
module pmcr_host_model (
    input wire logic i_clock,
    input wire logic [31:0] i_cfg_rdata,
    input wire logic i_cfg_rvalid,
    output logic o_cfg_wr,
    output logic o_cfg_rd,
    output logic [7:0] o_cfg_addr,
    output logic [3:0] o_cfg_be,
    output logic [31:0] o_cfg_wdata
);
    logic test_mode = 1'b0;
    initial begin
        o_cfg_wr = 1'b0;
        o_cfg_rd = 1'b0;
        o_cfg_addr = 8'h00;
        o_cfg_be = 4'h0;
        o_cfg_wdata = 32'h0;
    end
    // Abort suppression and clock bypass bits stay clear outside test mode.
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                             input logic [31:0] d);
        @(posedge i_clock);
        o_cfg_wr <= 1'b1;
        o_cfg_addr <= a;
        o_cfg_be <= be;
        o_cfg_wdata <= test_mode ? d : d & ~32'h16;
        @(posedge i_clock);
        o_cfg_wr <= 1'b0;
        o_cfg_addr <= ~a;
        o_cfg_wdata <= ~d;
    endtask
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] d,
                            output logic ok);
        @(posedge i_clock);
        o_cfg_rd <= 1'b1;
        o_cfg_addr <= a;
        @(posedge i_clock);
        o_cfg_rd <= 1'b0;
        o_cfg_addr <= ~a;
        #1;
        ok = i_cfg_rvalid;
        d = i_cfg_rdata;
    endtask
endmodule
`default_nettype wire

//--- test/pci_misc_config_register_bench.sv
// Self-checking bench for the miscellaneous bus configuration register.
`timescale 1ns/1ps
`default_nettype none
module pci_misc_config_register_bench;
    import pmcr_pkg::*;
    logic i_clock = 1'b0, i_nrst = 1'b0, bus_reset = 1'b0;
    logic cfg_wr, cfg_rd, rvalid, ok;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be, cmd;
    logic [31:0] cfg_wdata, cfg_rdata, link_rdata, reg_m = 32'h0, rd, r;
    logic ee_present = 1'b0, ee_valid = 1'b0;
    logic [3:0] ee_word = 4'h0;
    logic [15:0] ee_data = 16'h0;
    logic pe = 1'b0, irq = 1'b0, me = 1'b0, lreq = 1'b0, breq = 1'b0;
    logic pin = 1'b1, mr_req = 1'b0, link_acc = 1'b0, link_act = 1'b1;
    logic [7:0] phases = 8'h00;
    logic [1:0] gdr = 2'b00, gen = 2'b00, gpio_out, gpio_oe;
    logic pme_d3, vid26, pme_req, cmd_valid, link_done, link_abort;
    logic scl, sda, lgate, bgate, pin_out, pin_oe;
    logic [7:0] plist [4] = '{8'h01, 8'h02, 8'h03, 8'hff};
    integer seed = 32'h8a61, fails = 0, tests_run = 0, cycles = 0;

    always #12.5 i_clock = ~i_clock;

    pmcr_host_model pmcr_host_model_inst (.i_clock(i_clock),
        .i_cfg_rdata(cfg_rdata), .i_cfg_rvalid(rvalid), .o_cfg_wr(cfg_wr),
        .o_cfg_rd(cfg_rd), .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be),
        .o_cfg_wdata(cfg_wdata));

    pmcr_misc_config pmcr_misc_config_inst (.i_clock(i_clock),
        .i_nrst(i_nrst), .i_bus_reset(bus_reset), .i_cfg_wr(cfg_wr),
        .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be),
        .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
        .o_cfg_rvalid(rvalid), .i_eeprom_present(ee_present),
        .i_eeprom_valid(ee_valid), .i_eeprom_word(ee_word),
        .i_eeprom_data(ee_data), .o_pme_from_d3cold_support(pme_d3),
        .o_vendor_id_bit26(vid26), .i_pme_enable(pe), .i_unmasked_irq(irq),
        .i_interrupt_mask_master_enable(me), .o_pme_request(pme_req),
        .i_master_read_req(mr_req), .i_master_read_phases(phases),
        .o_master_read_cmd(cmd), .o_master_read_cmd_valid(cmd_valid),
        .i_link_access(link_acc), .i_link_clock_active(link_act),
        .o_link_done(link_done), .o_link_rdata(link_rdata),
        .o_link_target_abort(link_abort), .i_gpio_drive(gdr),
        .i_gpio_enable(gen), .o_gpio_out(gpio_out), .o_gpio_oe(gpio_oe),
        .o_serial_clock(scl), .o_serial_data(sda),
        .i_link_clock_request(lreq), .i_bus_clock_request(breq),
        .o_link_clock_gate_enable(lgate), .o_bus_clock_gate_enable(bgate),
        .i_multifunction_pin_6(pin), .o_multifunction_pin_6(pin_out),
        .o_multifunction_pin_6_oe(pin_oe));

    task automatic summarize;
        $display("Comparisons: %0d, mismatches: %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic good, input string msg);
        tests_run = tests_run + 1;
        if (!good) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            check(1'b0, "timeout");
            summarize;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        logic [31:0] m;
        m = {16'h0, {8{be[1]}}, {8{be[0]}}} & 32'h871f;
        if (!pmcr_host_model_inst.test_mode) d = d & ~32'h16;
        if (a == 8'hf0) reg_m = (reg_m & ~m) | (d & m);
        pmcr_host_model_inst.cfg_write(a, be, d);
    endtask

    task automatic rd_chk(input logic [7:0] a);
        pmcr_host_model_inst.cfg_read(a, rd, ok);
        check(ok === 1'b1, "no read answer");
        check(rd === (a == 8'hf0 ? reg_m : 32'h0), "read data");
    endtask

    task automatic levels;
        r = $random(seed);
        @(posedge i_clock);
        {pe, irq, me, lreq, breq, pin} <= r[5:0];
        gdr <= r[7:6];
        gen <= r[9:8];
        repeat (8) @(posedge i_clock);
        #1;
        check(pme_d3 === reg_m[15], "cold wake mirror");
        check(vid26 === reg_m[10], "vendor bit 26");
        check(pme_req === (pe & irq & (reg_m[10] | me)), "wake");
        check(gpio_out === gdr, "gpio value");
        check(gpio_oe === (reg_m[3] ? 2'b00 : gen), "gpio enable");
        check({scl, sda} === (reg_m[3] ? gdr : 2'b11), "serial");
        check(lgate === (reg_m[2] | lreq), "link gate");
        check(bgate === (reg_m[1] | breq), "bus gate");
        check(pin_oe === (pin & (reg_m[0] | breq)), "clock run");
        check(pin_out === 1'b0, "clock run level");
    endtask

    task automatic mread(input logic [7:0] p);
        logic [3:0] e;
        e = (reg_m[9:8] == 2'b10) ? 4'hc : 4'he;
        if (p <= 8'h02 || reg_m[9:8] == 2'b01) e = 4'h6;
        @(posedge i_clock);
        mr_req <= 1'b1;
        phases <= p;
        @(posedge i_clock);
        mr_req <= 1'b0;
        phases <= ~p;
        #1;
        check(cmd_valid === 1'b1 && cmd === e, "read command");
    endtask

    task automatic link(input logic act);
        @(posedge i_clock);
        link_acc <= 1'b1;
        link_act <= act;
        @(posedge i_clock);
        link_acc <= 1'b0;
        #1;
        check(link_done === (!act && reg_m[4]), "link done");
        check(link_abort === (!act && !reg_m[4]), "abort");
        if (link_done === 1'b1) begin
            check(link_rdata === 32'hffff_ffff, "ff");
        end
    endtask

    task automatic eeload(input logic pres, input logic [3:0] w);
        logic [15:0] d;
        d = 16'($random(seed));
        if (pres && w == 4'hc) reg_m[9:8] = d[1:0];
        @(posedge i_clock);
        ee_present <= pres;
        ee_valid <= 1'b1;
        ee_word <= w;
        ee_data <= d;
        @(posedge i_clock);
        ee_valid <= 1'b0;
        ee_data <= ~d;
        rd_chk(8'hf0);
    endtask

    initial begin
        repeat (3) @(posedge i_clock);
        i_nrst <= 1'b1;
        rd_chk(8'hf0);
        levels;
        $display("test reset done");
        pmcr_host_model_inst.test_mode = 1'b1;
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            wr((i % 6 == 5) ? r[7:0] : 8'hf0, r[11:8], $random(seed));
            @(posedge i_clock);
            bus_reset <= 1'b1;
            @(posedge i_clock);
            bus_reset <= 1'b0;
            levels;
            rd_chk(8'hf0);
            rd_chk(8'hf4);
        end
        fork
            pmcr_host_model_inst.cfg_read(8'hf0, rd, ok);
            begin
                @(posedge i_clock);
                bus_reset <= 1'b1;
                @(posedge i_clock);
                bus_reset <= 1'b0;
            end
        join
        check(ok === 1'b0, "read kept despite bus reset");
        $display("test register done");
        for (int s = 0; s < 4; s++) begin
            wr(8'hf0, 4'h2, 32'(s) << 8);
            foreach (plist[k]) mread(plist[k]);
        end
        $display("test read command done");
        eeload(1'b1, 4'hc);
        eeload(1'b0, 4'hc);
        eeload(1'b1, 4'hb);
        $display("test eeprom done");
        for (int s = 0; s < 2; s++) begin
            wr(8'hf0, 4'h1, 32'(s) << 4);
            link(1'b0);
            link(1'b0);
            link(1'b1);
        end
        $display("test link done");
        @(posedge i_clock);
        i_nrst <= 1'b0;
        @(posedge i_clock);
        i_nrst <= 1'b1;
        reg_m = 32'h0;
        rd_chk(8'hf0);
        levels;
        $display("test second reset done");
        summarize;
    end
endmodule
`default_nettype wire
